// file: status_map.svh
`ifndef STATUS_MAP_SVH
`define STATUS_MAP_SVH

// register byte offsets
`define REG_CFG 4'h0
`define REG_CTRL 4'h4
`define REG_STATUS 4'h8
`define REG_FAULT 4'hC

// configuration register fields
`define CFG_BAUD_LSB 0
`define CFG_DATA8_BIT 3
`define CFG_PARITY_LSB 4
`define CFG_STOP2_BIT 6
`define CFG_CMD_BIT 7
`define CFG_RESET 8'h08

// control register fields
`define CTRL_TOOL_BIT 0
`define CTRL_ESC_BIT 1
`define CTRL_FAULT_BIT 2
`define CTRL_RESET 2'h0

// forced maintenance serial settings: 38400, 8, N, 1
`define SVC_BAUD 3'h2
`define SVC_DATA8 1'h1
`define SVC_PARITY 2'h0
`define SVC_STOP2 1'h0

// timing
`define CLK_PERIOD_NS 10
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define TOOL_BLINK_MS 1000
`define ESC_BLINK_MS 500
`define FAULT_BLINK_MS 250
`define REBOOT_MS 5000

`endif

// file: status_pkg.sv
package status_pkg;

    typedef enum logic [2:0] {
        BAUD_9600 = 3'h0,
        BAUD_19200 = 3'h1,
        BAUD_38400 = 3'h2,
        BAUD_57600 = 3'h3,
        BAUD_115200 = 3'h4
    } baud_t;

    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_EVEN = 2'h1,
        PAR_ODD = 2'h2
    } parity_t;

    typedef enum logic [2:0] {
        SRC_SEARCH = 3'h0,
        SRC_RX = 3'h1,
        SRC_SLEEP = 3'h2,
        SRC_TX = 3'h3,
        SRC_TOOL = 3'h4,
        SRC_ESC = 3'h5,
        SRC_FAULT = 3'h6
    } stat_src_t;

endpackage : status_pkg

// file: serial_cfg_if.sv
interface serial_cfg_if;
    logic [2:0] baud;
    logic data8;
    logic [1:0] parity;
    logic stop2;
    logic cmd_en;
    modport drv (output baud, output data8, output parity, output stop2, output cmd_en);
    modport use_side (input baud, input data8, input parity, input stop2, input cmd_en);
endinterface : serial_cfg_if

// file: ms_tick_div.sv
`include "status_map.svh"

module ms_tick_div #(
    parameter int CYCLES = `MS_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    output logic tick_out
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
        end else if (cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    assign tick_out = (cnt_q == LAST);
endmodule : ms_tick_div

// file: serial_override.sv
`include "status_map.svh"

module serial_override (
    input wire logic maint_in,
    input wire logic [7:0] cfg_in,
    input wire logic esc_in,
    serial_cfg_if.drv cfg_if
);
    // stored settings untouched; only the effective view is overridden
    always_comb begin
        if (maint_in) begin
            cfg_if.baud = `SVC_BAUD;
            cfg_if.data8 = `SVC_DATA8;
            cfg_if.parity = `SVC_PARITY;
            cfg_if.stop2 = `SVC_STOP2;
        end else begin
            cfg_if.baud = cfg_in[`CFG_BAUD_LSB +: 3];
            cfg_if.data8 = cfg_in[`CFG_DATA8_BIT];
            cfg_if.parity = cfg_in[`CFG_PARITY_LSB +: 2];
            cfg_if.stop2 = cfg_in[`CFG_STOP2_BIT];
        end
        cfg_if.cmd_en = maint_in | cfg_in[`CFG_CMD_BIT] | esc_in;
    end
endmodule : serial_override

// file: status_service_top.sv
// Decided for this implementation: the address-and-strobe port and the register addresses.
`include "status_map.svh"

module status_service_top #(
    parameter int MS_CYCLES = `MS_CYCLES,
    parameter int FAULT_CODE_W = 8
) (
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    // register port
    input wire logic [3:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT,
    // maintenance pin
    input wire logic SERVICE_N_IN,
    // radio core status
    input wire logic RX_FRAME_IN,
    input wire logic TX_START_IN,
    input wire logic TX_ACTIVE_IN,
    input wire logic LIGHT_SLEEP_IN,
    input wire logic FAULT_IN,
    input wire logic [FAULT_CODE_W-1:0] FAULT_CODE_IN,
    // status pin
    output logic STAT_OUT,
    // effective serial settings
    output logic [2:0] BAUD_OUT,
    output logic DATA8_OUT,
    output logic [1:0] PARITY_OUT,
    output logic STOP2_OUT,
    output logic CMD_ENABLE_OUT,
    output logic MAINT_MODE_OUT,
    // fault handling
    output logic RADIO_BLOCK_OUT,
    output logic REBOOT_OUT
);

    logic maint;
    logic ms_tick;
    logic [7:0] cfg_q;
    logic tool_q;
    logic esc_q;
    logic fault_q;
    logic fault_set;
    logic reboot;
    logic [FAULT_CODE_W-1:0] fault_code_q;
    logic [12:0] reboot_ms_q;
    logic [9:0] blink_ms_q;
    logic blink_q;
    logic tx_lvl_q;
    logic stat_q;
    logic stat_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    status_pkg::stat_src_t src;
    status_pkg::stat_src_t src_q;

    serial_cfg_if cfg_bus ();

    assign maint = ~SERVICE_N_IN;

    function automatic logic [9:0] blink_ms(input status_pkg::stat_src_t s);
        case (s)
            status_pkg::SRC_TOOL: blink_ms = 10'(`TOOL_BLINK_MS);
            status_pkg::SRC_ESC: blink_ms = 10'(`ESC_BLINK_MS);
            status_pkg::SRC_FAULT: blink_ms = 10'(`FAULT_BLINK_MS);
            default: blink_ms = 10'h000;
        endcase
    endfunction : blink_ms

    ms_tick_div #(
        .CYCLES(MS_CYCLES)
    ) u_tick (
        .clk_in(CLOCK_IN),
        .rst_n_in(RST_N_IN),
        .tick_out(ms_tick)
    );

    serial_override u_override (
        .maint_in(maint),
        .cfg_in(cfg_q),
        .esc_in(esc_q),
        .cfg_if(cfg_bus)
    );

    // configuration store, written only by software
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cfg_q <= `CFG_RESET;
        end else if (WR_IN && ADDR_IN == `REG_CFG) begin
            cfg_q <= WDATA_IN[7:0];
        end
    end

    // tool connection and escape-enabled commands
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tool_q <= 1'h0;
            esc_q <= 1'h0;
        end else if (WR_IN && ADDR_IN == `REG_CTRL) begin
            tool_q <= WDATA_IN[`CTRL_TOOL_BIT];
            esc_q <= WDATA_IN[`CTRL_ESC_BIT];
        end
    end

    // fault entry and timed reboot; set wins over clear
    assign fault_set = FAULT_IN | (WR_IN && ADDR_IN == `REG_CTRL && WDATA_IN[`CTRL_FAULT_BIT]);
    assign reboot = fault_q && ms_tick && reboot_ms_q == 13'(`REBOOT_MS - 1);

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            fault_q <= 1'h0;
        end else if (fault_set) begin
            fault_q <= 1'h1;
        end else if (reboot) begin
            fault_q <= 1'h0;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            reboot_ms_q <= 13'h0000;
        end else if (!fault_q || reboot) begin
            reboot_ms_q <= 13'h0000;
        end else if (ms_tick) begin
            reboot_ms_q <= reboot_ms_q + 13'h0001;
        end
    end

    // code survives the reboot for the tools to read
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            fault_code_q <= '0;
        end else if (FAULT_IN) begin
            fault_code_q <= FAULT_CODE_IN;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            REBOOT_OUT <= 1'h0;
        end else begin
            REBOOT_OUT <= reboot;
        end
    end

    assign RADIO_BLOCK_OUT = fault_q;

    // pattern source by priority
    always_comb begin
        if (fault_q) begin
            src = status_pkg::SRC_FAULT;
        end else if (tool_q) begin
            src = status_pkg::SRC_TOOL;
        end else if (esc_q && !cfg_q[`CFG_CMD_BIT]) begin
            src = status_pkg::SRC_ESC;
        end else if (LIGHT_SLEEP_IN) begin
            src = status_pkg::SRC_SLEEP;
        end else if (TX_ACTIVE_IN) begin
            src = status_pkg::SRC_TX;
        end else if (RX_FRAME_IN) begin
            src = status_pkg::SRC_RX;
        end else begin
            src = status_pkg::SRC_SEARCH;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            src_q <= status_pkg::SRC_SEARCH;
        end else begin
            src_q <= src;
        end
    end

    // interval blinker; restarts when the pattern changes
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            blink_ms_q <= 10'h000;
            blink_q <= 1'h1;
        end else if (src != src_q) begin
            blink_ms_q <= 10'h000;
            blink_q <= 1'h1;
        end else if (ms_tick) begin
            if (blink_ms_q == blink_ms(src) - 10'h001) begin
                blink_ms_q <= 10'h000;
                blink_q <= ~blink_q;
            end else begin
                blink_ms_q <= blink_ms_q + 10'h001;
            end
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tx_lvl_q <= 1'h1;
        end else if (TX_START_IN) begin
            tx_lvl_q <= ~tx_lvl_q;
        end
    end

    always_comb begin
        case (src)
            status_pkg::SRC_SEARCH: stat_d = 1'h1;
            status_pkg::SRC_RX: stat_d = 1'h0;
            status_pkg::SRC_SLEEP: stat_d = 1'h0;
            status_pkg::SRC_TX: stat_d = tx_lvl_q;
            status_pkg::SRC_TOOL: stat_d = blink_q;
            status_pkg::SRC_ESC: stat_d = blink_q;
            status_pkg::SRC_FAULT: stat_d = blink_q;
            default: stat_d = 1'h1;
        endcase
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            stat_q <= 1'h1;
        end else begin
            stat_q <= stat_d;
        end
    end

    assign STAT_OUT = stat_q;
    assign BAUD_OUT = cfg_bus.baud;
    assign DATA8_OUT = cfg_bus.data8;
    assign PARITY_OUT = cfg_bus.parity;
    assign STOP2_OUT = cfg_bus.stop2;
    assign CMD_ENABLE_OUT = cfg_bus.cmd_en;
    assign MAINT_MODE_OUT = maint;

    // register read, data in the following cycle
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (ADDR_IN)
            `REG_CFG: rdata_d[7:0] = cfg_q;
            `REG_CTRL: rdata_d[2:0] = {fault_q, esc_q, tool_q};
            `REG_STATUS: rdata_d[7:0] = {1'h0, src, maint, cfg_bus.cmd_en, fault_q, stat_q};
            `REG_FAULT: rdata_d[FAULT_CODE_W-1:0] = fault_code_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rdata_q <= 32'h0000_0000;
        end else if (RD_IN) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign RDATA_OUT = rdata_q;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence tx_start_s;
        TX_START_IN && src == status_pkg::SRC_TX;
    endsequence

    sequence tx_hold_s;
        src == status_pkg::SRC_TX ##1 src == status_pkg::SRC_TX;
    endsequence

    a_service_baud: assert property (!SERVICE_N_IN |-> BAUD_OUT == `SVC_BAUD && DATA8_OUT
        && PARITY_OUT == `SVC_PARITY && !STOP2_OUT)
        else $error("maintenance settings not forced");

    a_cfg_kept: assert property (!SERVICE_N_IN && !(WR_IN && ADDR_IN == `REG_CFG)
        |=> $stable(cfg_q))
        else $error("configuration changed by maintenance input");

    a_service_release: assert property ($rose(SERVICE_N_IN) |->
        BAUD_OUT == cfg_q[`CFG_BAUD_LSB +: 3] && STOP2_OUT == cfg_q[`CFG_STOP2_BIT])
        else $error("configured settings not restored");

    a_cmd_forced: assert property (!SERVICE_N_IN |-> CMD_ENABLE_OUT)
        else $error("commands not forced on");

    a_search_high: assert property (src == status_pkg::SRC_SEARCH |=> STAT_OUT)
        else $error("status not high while searching");

    a_rx_low: assert property (src == status_pkg::SRC_RX |=> !STAT_OUT)
        else $error("status not low during frame");

    a_sleep_low: assert property (src == status_pkg::SRC_SLEEP |=> !STAT_OUT)
        else $error("status not low in light sleep");

    a_tx_toggle: assert property (tx_start_s ##0 tx_hold_s |=>
        STAT_OUT != $past(STAT_OUT))
        else $error("status did not toggle on transmission");

    a_fault_block: assert property (fault_set |=> RADIO_BLOCK_OUT)
        else $error("radio not blocked on fault");

    // a fault raised in the reboot cycle wins over the clear
    a_reboot_clear: assert property (reboot |=> REBOOT_OUT
        && (!RADIO_BLOCK_OUT || $past(fault_set)))
        else $error("reboot did not end fault state");

    a_fault_first: assert property (fault_q && tool_q |-> src == status_pkg::SRC_FAULT)
        else $error("fault pattern lost priority");

endmodule : status_service_top

// file: host_side_model.sv
module host_side_model (
    // clock
    input wire logic clk_in,
    // bench asks for the maintenance override
    input wire logic hold_low_in,
    // maintenance line towards the device
    output logic service_n_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // the line idles at the pull-up level until the host pulls it down
    initial service_n_out = 1'h1;
    always @(posedge clk_in) begin
        service_n_out <= hold_low_in ? 1'h0 : 1'h1;
    end
endmodule : host_side_model

// file: testbench.sv
`include "status_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 10;
    localparam int LIMIT = 99000;
    typedef struct packed {
        logic svc_n; logic [7:0] cfg; logic [1:0] ctrl; logic rx; logic slp; logic txa;
        logic [2:0] baud; logic d8; logic [1:0] par; logic st2; logic cmd; logic [2:0] src;
    } row_t;
    logic clk, rst_n, wr, rd, svc_req, service_n, rx_frame, tx_start, tx_active, sleep;
    logic fault, stat, data8, stop2, cmd_en, maint, block, reboot;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, d;
    logic [7:0] fault_code;
    logic [2:0] baud;
    logic [1:0] parity;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0, n;
    logic s;
    row_t rows [7] = '{
        '{1'h1, 8'h08, 2'h0, 1'h0, 1'h0, 1'h0, 3'h0, 1'h1, 2'h0, 1'h0, 1'h0, 3'h0},
        '{1'h1, 8'hD4, 2'h0, 1'h1, 1'h0, 1'h0, 3'h4, 1'h0, 2'h1, 1'h1, 1'h1, 3'h1},
        '{1'h0, 8'hD4, 2'h0, 1'h0, 1'h1, 1'h0, 3'h2, 1'h1, 2'h0, 1'h0, 1'h1, 3'h2},
        '{1'h0, 8'h08, 2'h0, 1'h1, 1'h1, 1'h0, 3'h2, 1'h1, 2'h0, 1'h0, 1'h1, 3'h2},
        '{1'h1, 8'h08, 2'h2, 1'h0, 1'h0, 1'h1, 3'h0, 1'h1, 2'h0, 1'h0, 1'h1, 3'h5},
        '{1'h1, 8'h88, 2'h2, 1'h0, 1'h0, 1'h1, 3'h0, 1'h1, 2'h0, 1'h0, 1'h1, 3'h3},
        '{1'h1, 8'h08, 2'h3, 1'h1, 1'h0, 1'h0, 3'h0, 1'h1, 2'h0, 1'h0, 1'h1, 3'h4}
    };

    host_side_model HOST (.clk_in(clk), .hold_low_in(svc_req), .service_n_out(service_n));

    status_service_top #(.MS_CYCLES(MSC)) DUT (
        .CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .SERVICE_N_IN(service_n), .RX_FRAME_IN(rx_frame),
        .TX_START_IN(tx_start), .TX_ACTIVE_IN(tx_active), .LIGHT_SLEEP_IN(sleep),
        .FAULT_IN(fault), .FAULT_CODE_IN(fault_code), .STAT_OUT(stat), .BAUD_OUT(baud),
        .DATA8_OUT(data8), .PARITY_OUT(parity), .STOP2_OUT(stop2), .CMD_ENABLE_OUT(cmd_en),
        .MAINT_MODE_OUT(maint), .RADIO_BLOCK_OUT(block), .REBOOT_OUT(reboot)
    );

    always #5 clk = ~clk;

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc >= LIMIT) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        v = rdata;
    endtask : reg_rd

    // time between two consecutive edges of the status pin
    task automatic measure(input string nm, input int exp);
        int k;
        for (int j = 0; j < 2; j++) begin
            s = stat;
            k = 0;
            while (stat === s && k < 3 * exp) begin
                tick(1);
                k++;
            end
        end
        check(nm, k, exp);
    endtask : measure

    initial begin
        {clk, rst_n, wr, rd, svc_req, rx_frame, tx_start, tx_active, sleep, fault} = 10'h0;
        addr = 4'h0;
        wdata = 32'h0;
        fault_code = 8'h00;
        tick(3);
        check("stat_rst", stat, 1'h1);
        check("reboot_rst", reboot, 1'h0);
        check("block_rst", block, 1'h0);
        check("rdata_rst", rdata, 32'h0);
        tick(3);
        rst_n <= 1'h1;
        reg_rd(4'h0, d);
        check("cfg_rst", d, 32'h08);
        foreach (rows[i]) begin
            reg_wr(4'h0, {24'h0, rows[i].cfg});
            reg_wr(4'h4, {30'h0, rows[i].ctrl});
            @(posedge clk);
            svc_req <= ~rows[i].svc_n;
            rx_frame <= rows[i].rx;
            sleep <= rows[i].slp;
            tx_active <= rows[i].txa;
            tick(4);
            check("baud", baud, rows[i].baud);
            check("data8", data8, rows[i].d8);
            check("parity", parity, rows[i].par);
            check("stop2", stop2, rows[i].st2);
            check("cmd", cmd_en, rows[i].cmd);
            check("maint", maint, !rows[i].svc_n);
            if (rows[i].src <= 3'h2) begin
                check("stat", stat, rows[i].src == 3'h0);
            end
            reg_rd(4'h8, d);
            check("src", d[6:4], rows[i].src);
        end
        // override leaves the stored settings alone and gives them back on release
        reg_wr(4'h0, 32'h54);
        reg_wr(4'h4, 32'h0);
        @(posedge clk);
        {svc_req, rx_frame, sleep, tx_active} <= 4'h8;
        tick(4);
        check("svc_baud", baud, status_pkg::BAUD_38400);
        reg_rd(4'h0, d);
        check("cfg_kept", d, 32'h54);
        reg_rd(4'h8, d);
        check("mode_kept", d[6:4], status_pkg::SRC_SEARCH);
        svc_req <= 1'h0;
        tick(4);
        check("baud_back", baud, 3'h4);
        check("cmd_back", cmd_en, 1'h0);
        check("parity_back", parity, status_pkg::PAR_EVEN);
        tx_active <= 1'h1;
        tick(4);
        for (int j = 0; j < 2; j++) begin
            s = stat;
            @(posedge clk);
            tx_start <= 1'h1;
            @(posedge clk);
            tx_start <= 1'h0;
            tick(4);
            check("tx_toggle", stat, !s);
        end
        tx_active <= 1'h0;
        reg_wr(4'h4, 32'h2);
        measure("esc_half", `ESC_BLINK_MS * MSC);
        reg_wr(4'h4, 32'h1);
        measure("tool_half", `TOOL_BLINK_MS * MSC);
        @(posedge clk);
        fault <= 1'h1;
        fault_code <= 8'h5A;
        @(posedge clk);
        fault <= 1'h0;
        t0 = cyc;
        tick(2);
        check("block", block, 1'h1);
        reg_rd(4'h8, d);
        check("fault_src", d[6:4], status_pkg::SRC_FAULT);
        measure("fault_half", `FAULT_BLINK_MS * MSC);
        reg_rd(4'hC, d);
        check("code", d[7:0], 8'h5A);
        n = 0;
        while (reboot !== 1'h1 && n < 60000) begin
            tick(1);
            n++;
        end
        n = cyc - t0;
        check("reboot_at", n >= (`REBOOT_MS - 1) * MSC && n <= (`REBOOT_MS + 1) * MSC, 1'h1);
        tick(1);
        check("unblock", block, 1'h0);
        reg_rd(4'hC, d);
        check("code_kept", d[7:0], 8'h5A);
        // fault raised by software instead of the radio core
        reg_wr(4'h4, 32'h4);
        tick(1);
        check("ctrl_fault", block, 1'h1);
        reg_rd(4'h4, d);
        check("ctrl_read", d, 32'h4);
        final_report();
    end
endmodule : testbench
